/* bench/smi_core_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// core and pin side: answers requests with an ack pulse after a wait
module smi_core_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       irq_request,
    input  wire logic       ack_enable,
    input  wire logic [3:0] ack_wait,
    input  wire logic       pin_a_level,
    input  wire logic       pin_b_level,
    output logic            irq_ack,
    output logic            ext_irq_pin_a,
    output logic            ext_irq_pin_b
);
    logic [3:0] wait_count;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ack       <= 1'b0;
            wait_count    <= 4'h0;
            ext_irq_pin_a <= 1'b0;
            ext_irq_pin_b <= 1'b0;
        end else begin
            ext_irq_pin_a <= pin_a_level;
            ext_irq_pin_b <= pin_b_level;
            irq_ack       <= 1'b0;
            // one ack per request; a late ack models a slow core
            if (irq_request && ack_enable && !irq_ack) begin
                if (wait_count >= ack_wait) begin
                    irq_ack    <= 1'b1;
                    wait_count <= 4'h0;
                end else begin
                    wait_count <= wait_count + 4'h1;
                end
            end else begin
                wait_count <= 4'h0;
            end
        end
    end
endmodule // smi_core_model

`default_nettype wire

/* bench/smi_supply_monitor_irq_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module smi_supply_monitor_irq_bench import smi_pkg::*;;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp_rd;
    } smi_row_type;

    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err, seen;
    logic        supply_below, pin_a_level, pin_b_level, ack_enable, irq_ack;
    logic        ext_irq_pin_a, ext_irq_pin_b, monitor_power_on, low_supply_flag;
    logic        irq_request, wake_request;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  ack_wait;
    logic [2:0]  threshold_code;
    logic [15:0] threshold_millivolts;
    int          n_errors, checks, n;
    smi_row_type rows [8] = '{
        '{ADDR_MONITOR_CTRL, 8'hff, 8'h17}, '{ADDR_EDGE_SELECT, 8'hff, 8'h0f},
        '{ADDR_PRIMARY_A, 8'hff, 8'h7f},    '{ADDR_PRIMARY_B, 8'hff, 8'hff},
        '{ADDR_PRIMARY_C, 8'hff, 8'hff},    '{ADDR_MULTI_A, 8'hff, 8'h33},
        '{ADDR_MULTI_B, 8'hff, 8'hff},      '{ADDR_MULTI_C, 8'hff, 8'h33}};
    logic [15:0] mv_table [8] = '{16'h07d0, 16'h0898, 16'h0960, 16'h0a8c,
                                  16'h0bb8, 16'h0ce4, 16'h0e10, 16'h0fa0};

    smi_supply_monitor_irq uut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .supply_below_threshold(supply_below), .ext_irq_pin_a(ext_irq_pin_a),
        .ext_irq_pin_b(ext_irq_pin_b), .irq_ack(irq_ack),
        .monitor_power_on(monitor_power_on), .threshold_code(threshold_code),
        .threshold_millivolts(threshold_millivolts), .low_supply_flag(low_supply_flag),
        .irq_request(irq_request), .wake_request(wake_request));

    smi_core_model core (.clk(clk), .reset_n(reset_n), .irq_request(irq_request),
        .ack_enable(ack_enable), .ack_wait(ack_wait), .pin_a_level(pin_a_level),
        .pin_b_level(pin_b_level), .irq_ack(irq_ack), .ext_irq_pin_a(ext_irq_pin_a),
        .ext_irq_pin_b(ext_irq_pin_b));

    // ======================================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // registers written at the access edge are settled one edge later
        @(posedge clk);
    endtask

    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ======================================================================
    // clock, watchdog
    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    initial begin
        #(CLK_PERIOD_NS * 20000);
        n_errors++;
        finish_test;
    end

    // ======================================================================
    // main sequence
    initial begin
        {reset_n, psel, penable, pwrite, supply_below, pin_a_level, pin_b_level} = 7'h00;
        {paddr, pwdata, ack_enable, ack_wait} = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        chk(32'(threshold_millivolts), 32'h07d0);
        apb(1'b1, 8'h20, 32'hff);
        chk(32'(err), 32'h1);
        apb(1'b1, 8'h02, 32'hff);
        apb(1'b0, ADDR_MONITOR_CTRL, 32'h0);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, {24'h0, rows[i].wdata});
            apb(1'b0, rows[i].addr, 32'h0);
            chk(rd, {24'h0, rows[i].exp_rd});
            apb(1'b1, rows[i].addr, 32'h0);
        end
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, ADDR_MONITOR_CTRL, 32'(i));
            chk(32'(threshold_millivolts), 32'(mv_table[i]));
            chk(32'(threshold_code), 32'(i));
        end
        // monitor off: comparator ignored
        supply_below <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'(low_supply_flag), 32'h0);
        chk(32'(monitor_power_on), 32'h0);
        supply_below <= 1'b0;
        apb(1'b1, ADDR_MONITOR_CTRL, 32'h10);
        chk(32'(monitor_power_on), 32'h1);
        repeat (10) @(posedge clk);
        apb(1'b1, ADDR_MULTI_C, 32'h01);
        // short low episode must not reach the request flag
        supply_below <= 1'b1;
        repeat (60) @(posedge clk);
        apb(1'b0, ADDR_MONITOR_CTRL, 32'h0);
        chk(rd, 32'h30);
        supply_below <= 1'b0;
        repeat (5) @(posedge clk);
        chk(32'(low_supply_flag), 32'h0);
        repeat (130) @(posedge clk);
        apb(1'b0, ADDR_MULTI_C, 32'h0);
        chk(rd, 32'h01);
        apb(1'b1, ADDR_PRIMARY_B, 32'h02);
        apb(1'b1, ADDR_PRIMARY_A, 32'h01);
        ack_enable <= 1'b1;
        ack_wait <= 4'h2;
        @(posedge clk);
        supply_below <= 1'b1;
        n = 0;
        while (wake_request !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= 125 && n <= 132), 32'h1);
        repeat (10) @(posedge clk);
        apb(1'b0, ADDR_MULTI_C, 32'h0);
        chk(rd, 32'h11);
        apb(1'b0, ADDR_PRIMARY_B, 32'h0);
        chk(rd, 32'h22);
        apb(1'b0, ADDR_PRIMARY_A, 32'h0);
        chk(rd, 32'h0);
        // preset flag: no wake on the next low episode
        supply_below <= 1'b0;
        apb(1'b1, ADDR_MULTI_C, 32'h11);
        supply_below <= 1'b1;
        seen = 1'b0;
        repeat (140) @(posedge clk) seen |= wake_request;
        chk(32'(seen), 32'h0);
        supply_below <= 1'b0;
        ack_enable <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_EDGE_SELECT, 32'(m | (m << 2)));
            for (int lv = 1; lv >= 0; lv--) begin
                apb(1'b1, ADDR_PRIMARY_A, 32'h0);
                apb(1'b1, ADDR_PRIMARY_C, 32'h0);
                pin_a_level <= lv[0];
                pin_b_level <= lv[0];
                repeat (8) @(posedge clk);
                seen = (lv == 1) ? m[0] : m[1];
                apb(1'b0, ADDR_PRIMARY_A, 32'h0);
                chk(rd, {27'h0, seen, 4'h0});
                apb(1'b0, ADDR_PRIMARY_C, 32'h0);
                chk(rd, {25'h0, seen, 6'h0});
                chk(32'(irq_request), 32'h0);
            end
        end
        // flag with enable but global off, then global on, then serviced
        apb(1'b1, ADDR_EDGE_SELECT, 32'h01);
        apb(1'b1, ADDR_PRIMARY_A, 32'h02);
        pin_a_level <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(irq_request), 32'h0);
        apb(1'b1, ADDR_PRIMARY_A, 32'h13);
        chk(32'(irq_request), 32'h1);
        ack_enable <= 1'b1;
        repeat (12) @(posedge clk);
        chk(32'(irq_request), 32'h0);
        apb(1'b0, ADDR_PRIMARY_A, 32'h0);
        chk(rd, 32'h12);
        // second reset in mid-run
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, ADDR_EDGE_SELECT, 32'h0);
        chk(rd, 32'h0);
        chk(32'(threshold_millivolts), 32'h07d0);
        finish_test;
    end
endmodule // smi_supply_monitor_irq_bench

`default_nettype wire

/* design/smi_supply_monitor_irq.sv */
// Functional notes
// - three-bit code selects threshold 2.0, 2.2, 2.4, 2.7, 3.0, 3.3, 3.6, 4.0 volts
// - low-supply flag at bit 5 reads 1 while supply below threshold
// - enable bit 4 powers the monitor; cleared switches detection off
// - control bits 7..6 and 3 read zero
// - monitor keeps running in power-down while enabled
// - low-supply flag follows comparator unfiltered
// - monitor request flag sets only after fixed delay of low supply
// - setting the monitor request flag wakes from sleep or idle
// - monitor request goes through shared multi-function interrupt; polling still works
// - edge bits 1..0 pick pin a detection: off, rise, fall, both
// - edge bits 3..2 pick pin b detection, same encoding
// - edge register bits 7..4 read zero
// - hardware sets request flags; enables other than the global enable written only by software
// - three primary and three multi-function enable/flag registers
// - external requests come from the two pins as edge-qualified
// - flags recorded even when disabled; vector request needs enable
// - global enable cleared blocks all interrupts
// - global enable clears itself when an interrupt is serviced
`timescale 1ns/10ps
`default_nettype none

module smi_supply_monitor_irq
    import smi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        supply_below_threshold,
    input  wire logic        ext_irq_pin_a,
    input  wire logic        ext_irq_pin_b,
    input  wire logic        irq_ack,
    output logic             monitor_power_on,
    output logic [2:0]       threshold_code,
    output logic [15:0]      threshold_millivolts,
    output logic             low_supply_flag,
    output logic             irq_request,
    output logic             wake_request
);

    // ======================================================================
    // helpers
    function automatic logic edge_hit(input logic [1:0] mode, input logic now,
                                      input logic prev);
        logic rise;
        logic fall;
        rise = now & ~prev;
        fall = ~now & prev;
        unique case (smi_edge_mode_type'(mode))
            SMI_EDGE_OFF:     edge_hit = 1'b0;
            SMI_EDGE_RISING:  edge_hit = rise;
            SMI_EDGE_FALLING: edge_hit = fall;
            SMI_EDGE_BOTH:    edge_hit = rise | fall;
        endcase
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] wd,
                                         input logic [7:0] mask, input logic hit);
        merge = hit ? (wd & mask) : cur;
    endfunction

    // ======================================================================
    // state
    smi_state_type state;
    smi_state_type next_state;

    logic       setup_phase;
    logic       wr_access;
    logic       lsf;
    logic       pin_a_edge;
    logic       pin_b_edge;
    logic       lvf_hw_set;
    logic       pending;
    logic       mapped;
    logic [7:0] rd_byte;
    logic [7:0] wd;

    // ======================================================================
    // observation
    assign monitor_power_on     = state.monitor_ctrl[POS_MONITOR_ENABLE];
    assign threshold_code       = state.monitor_ctrl[2:0];
    assign threshold_millivolts = THRESHOLD_MV[state.monitor_ctrl[2:0]];
    // no filter: the flag tracks the comparator, chatter included
    assign lsf                  = monitor_power_on & state.cmp_sync[1];
    assign low_supply_flag      = lsf;
    assign pin_a_edge = edge_hit(state.edge_select[1:0],
                                 state.pin_a_sync[1], state.pin_a_sync[2]);
    assign pin_b_edge = edge_hit(state.edge_select[3:2],
                                 state.pin_b_sync[1], state.pin_b_sync[2]);
    assign lvf_hw_set = lsf && (state.delay_count == DELAY_W'(MONITOR_IRQ_DELAY_CYC - 1));
    // sub-source flags only feed the shared multi-function lines
    assign pending = |(state.primary_a[6:4] & state.primary_a[3:1])
                   | |(state.primary_b[7:4] & state.primary_b[3:0])
                   | |(state.primary_c[7:4] & state.primary_c[3:0]);
    assign irq_request  = state.primary_a[POS_GLOBAL_ENABLE] & pending;
    assign wake_request = state.wake;
    assign pready       = 1'b1;
    assign prdata       = state.prdata;
    assign pslverr      = state.pslverr;

    assign setup_phase = psel & ~penable;
    assign wr_access   = psel & penable & pwrite & ~state.pslverr;
    assign wd          = pwdata[7:0];

    // ======================================================================
    // read decode, captured in the setup cycle so prdata comes from a flop
    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        unique case (paddr)
            ADDR_MONITOR_CTRL: rd_byte = {2'b00, lsf, state.monitor_ctrl[4],
                                          1'b0, state.monitor_ctrl[2:0]};
            ADDR_EDGE_SELECT:  rd_byte = {4'h0, state.edge_select[3:0]};
            ADDR_PRIMARY_A:    rd_byte = state.primary_a & MASK_PRIMARY_A;
            ADDR_PRIMARY_B:    rd_byte = state.primary_b;
            ADDR_PRIMARY_C:    rd_byte = state.primary_c;
            ADDR_MULTI_A:      rd_byte = state.multi_a & MASK_MULTI_AC;
            ADDR_MULTI_B:      rd_byte = state.multi_b;
            ADDR_MULTI_C:      rd_byte = state.multi_c & MASK_MULTI_AC;
            default:           mapped  = 1'b0;
        endcase
    end

    // ======================================================================
    // next state
    always_comb begin
        next_state = state;

        // synchronisers: logic reads the second comparator stage and the second and third pin stages
        next_state.cmp_sync   = {state.cmp_sync[0], supply_below_threshold};
        next_state.pin_a_sync = {state.pin_a_sync[1:0], ext_irq_pin_a};
        next_state.pin_b_sync = {state.pin_b_sync[1:0], ext_irq_pin_b};

        if (setup_phase) begin
            next_state.prdata  = {24'h000000, rd_byte};
            next_state.pslverr = ~mapped;
        end

        // software writes land first; enables change only here, except the global enable cleared on service
        if (wr_access) begin
            next_state.monitor_ctrl = merge(state.monitor_ctrl, wd, MASK_MONITOR_CTRL,
                                            paddr == ADDR_MONITOR_CTRL);
            next_state.edge_select  = merge(state.edge_select, wd, MASK_EDGE_SELECT,
                                            paddr == ADDR_EDGE_SELECT);
            next_state.primary_a    = merge(state.primary_a, wd, MASK_PRIMARY_A,
                                            paddr == ADDR_PRIMARY_A);
            next_state.primary_b    = merge(state.primary_b, wd, MASK_FULL,
                                            paddr == ADDR_PRIMARY_B);
            next_state.primary_c    = merge(state.primary_c, wd, MASK_FULL,
                                            paddr == ADDR_PRIMARY_C);
            next_state.multi_a      = merge(state.multi_a, wd, MASK_MULTI_AC,
                                            paddr == ADDR_MULTI_A);
            next_state.multi_b      = merge(state.multi_b, wd, MASK_FULL,
                                            paddr == ADDR_MULTI_B);
            next_state.multi_c      = merge(state.multi_c, wd, MASK_MULTI_AC,
                                            paddr == ADDR_MULTI_C);
        end

        // delay timer: restarts whenever the low condition drops
        if (!lsf) begin
            next_state.delay_count = '0;
        end else if (state.delay_count < DELAY_W'(MONITOR_IRQ_DELAY_CYC)) begin
            next_state.delay_count = state.delay_count + DELAY_W'(1);
        end

        // hardware sets after software writes, so a set always wins
        next_state.wake = 1'b0;
        if (lvf_hw_set) begin
            next_state.multi_c[POS_MONITOR_IRQ_FL] = 1'b1;
            // a flag already set by software suppresses the wake
            next_state.wake = ~state.multi_c[POS_MONITOR_IRQ_FL];
            if (state.multi_c[POS_MONITOR_IRQ_EN]) begin
                next_state.primary_b[POS_MULTI2_FLAG] = 1'b1;
            end
        end
        if (pin_a_edge) begin
            next_state.primary_a[POS_PIN_A_FLAG] = 1'b1;
        end
        if (pin_b_edge) begin
            next_state.primary_c[POS_PIN_B_FLAG] = 1'b1;
        end

        // servicing drops the global enable; flags keep recording
        if (irq_ack) begin
            next_state.primary_a[POS_GLOBAL_ENABLE] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    thr_map_a: assert property (
        wr_access && paddr == ADDR_MONITOR_CTRL |=>
            threshold_millivolts == THRESHOLD_MV[$past(pwdata[2:0])])
        else $error("threshold table mismatch");

    low_flag_read_a: assert property (
        setup_phase && paddr == ADDR_MONITOR_CTRL |=> prdata[5] == $past(lsf))
        else $error("low flag read wrong");

    off_flag_a: assert property (!monitor_power_on |-> !low_supply_flag)
        else $error("low flag while monitor off");

    ctrl_rsvd_a: assert property (
        setup_phase && paddr == ADDR_MONITOR_CTRL |=>
            prdata[7:6] == 2'b00 && prdata[3] == 1'b0)
        else $error("control reserved bits nonzero");

    edge_rsvd_a: assert property (
        setup_phase && paddr == ADDR_EDGE_SELECT |=> prdata[7:4] == 4'h0)
        else $error("edge reserved bits nonzero");

    irq_delay_a: assert property (
        $rose(state.multi_c[POS_MONITOR_IRQ_FL]) && !$past(wr_access) |->
            $past(lsf) && $past(state.delay_count) ==
                DELAY_W'(MONITOR_IRQ_DELAY_CYC - 1))
        else $error("monitor flag set early");

    delay_reset_a: assert property (!lsf |=> state.delay_count == '0)
        else $error("delay not restarted");

    wake_a: assert property (
        lvf_hw_set && !state.multi_c[POS_MONITOR_IRQ_FL] |=> wake_request ##1 !wake_request)
        else $error("wake pulse wrong");

    pin_a_rise_a: assert property (
        state.edge_select[1:0] == 2'h1 && state.pin_a_sync[1] && !state.pin_a_sync[2]
            |=> state.primary_a[POS_PIN_A_FLAG])
        else $error("pin a flag missed");

    pin_b_off_a: assert property (
        state.edge_select[3:2] == 2'h0 && !state.primary_c[POS_PIN_B_FLAG] && !wr_access
            |=> !state.primary_c[POS_PIN_B_FLAG])
        else $error("pin b flag while disabled");

    global_block_a: assert property (
        !state.primary_a[POS_GLOBAL_ENABLE] |-> !irq_request)
        else $error("interrupt while globally off");

    ack_clear_a: assert property (irq_ack |=> !irq_request)
        else $error("global enable kept after ack");

    set_wins_a: assert property (
        pin_b_edge && wr_access && paddr == ADDR_PRIMARY_C |=>
            state.primary_c[POS_PIN_B_FLAG])
        else $error("clear beat hardware set");

    // ======================================================================
    // bus, flag and enable checks
    rd_upper_a: assert property (
        setup_phase
            |=> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");

    unaligned_err_a: assert property (
        setup_phase && paddr[1:0] != 2'b00
            |=> pslverr)
        else $error("unaligned address accepted");

    high_addr_err_a: assert property (
        setup_phase && paddr > ADDR_MULTI_C
            |=> pslverr)
        else $error("unmapped address accepted");

    lsf_follow_a: assert property (
        monitor_power_on && state.cmp_sync[1]
            |-> low_supply_flag)
        else $error("low flag missed comparator");

    lsf_drop_a: assert property (
        !state.cmp_sync[1]
            |-> !low_supply_flag)
        else $error("low flag without low supply");

    route_a: assert property (
        lvf_hw_set && state.multi_c[POS_MONITOR_IRQ_EN]
            |=> state.primary_b[POS_MULTI2_FLAG])
        else $error("monitor request not routed");

    enables_a: assert property (
        !wr_access
            |=> $stable(state.primary_a[3:1]) && $stable(state.primary_b[3:0])
                && $stable(state.primary_c[3:0]))
        else $error("enable changed by hardware");

    lve_hold_a: assert property (
        !wr_access
            |=> $stable(state.multi_c[POS_MONITOR_IRQ_EN]))
        else $error("monitor enable changed by hardware");

    flag_kept_a: assert property (
        pin_a_edge && !state.primary_a[1]
            |=> state.primary_a[POS_PIN_A_FLAG])
        else $error("disabled flag not recorded");

    pin_b_fall_a: assert property (
        state.edge_select[3:2] == 2'h2 && !state.pin_b_sync[1] && state.pin_b_sync[2]
            |=> state.primary_c[POS_PIN_B_FLAG])
        else $error("pin b fall missed");

    pin_a_off_a: assert property (
        state.edge_select[1:0] == 2'h0 && !state.primary_a[POS_PIN_A_FLAG] && !wr_access
            |=> !state.primary_a[POS_PIN_A_FLAG])
        else $error("pin a flag while disabled");

    both_edge_a: assert property (
        state.edge_select[1:0] == 2'h3 && state.pin_a_sync[1] != state.pin_a_sync[2]
            |=> state.primary_a[POS_PIN_A_FLAG])
        else $error("pin a either edge missed");

    wake_src_a: assert property (
        wake_request
            |-> $past(lvf_hw_set))
        else $error("wake without monitor set");

    edge_hold_a: assert property (
        state.edge_select[7:4] == 4'h0)
        else $error("edge reserved bits stored");

    // ======================================================================
    // coverage of the main scenarios
    cov_lvf_irq: cover property (lvf_hw_set ##1 irq_request);
    cov_pin_b_fall: cover property (state.edge_select[3:2] == 2'h2 && pin_b_edge);
    cov_wake: cover property (wake_request);
    cov_both_edges: cover property (state.edge_select[1:0] == 2'h3 && pin_a_edge);
    cov_ack: cover property (irq_request ##1 irq_ack);

endmodule // smi_supply_monitor_irq

`default_nettype wire

/* pkg/smi_pkg.sv */
package smi_pkg;

    // ======================================================================
    // register map, byte addresses on the apb
    localparam logic [7:0] ADDR_MONITOR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_EDGE_SELECT  = 8'h04;
    localparam logic [7:0] ADDR_PRIMARY_A    = 8'h08;
    localparam logic [7:0] ADDR_PRIMARY_B    = 8'h0c;
    localparam logic [7:0] ADDR_PRIMARY_C    = 8'h10;
    localparam logic [7:0] ADDR_MULTI_A      = 8'h14;
    localparam logic [7:0] ADDR_MULTI_B      = 8'h18;
    localparam logic [7:0] ADDR_MULTI_C      = 8'h1c;

    // ======================================================================
    // writable bits and reset values
    localparam logic [7:0] MASK_MONITOR_CTRL = 8'h17;
    localparam logic [7:0] MASK_EDGE_SELECT  = 8'h0f;
    localparam logic [7:0] MASK_PRIMARY_A    = 8'h7f;
    localparam logic [7:0] MASK_FULL         = 8'hff;
    localparam logic [7:0] MASK_MULTI_AC     = 8'h33;
    localparam logic [7:0] RESET_BYTE        = 8'h00;

    // ======================================================================
    // field positions
    localparam int POS_THRESHOLD_LSB  = 0;
    localparam int POS_MONITOR_ENABLE = 4;
    localparam int POS_LOW_FLAG       = 5;
    localparam int POS_PIN_A_MODE     = 0;
    localparam int POS_PIN_B_MODE     = 2;
    localparam int POS_GLOBAL_ENABLE  = 0;
    localparam int POS_PIN_A_FLAG     = 4;
    localparam int POS_MULTI2_FLAG    = 5;
    localparam int POS_PIN_B_FLAG     = 6;
    localparam int POS_MONITOR_IRQ_EN = 0;
    localparam int POS_MONITOR_IRQ_FL = 4;

    // ======================================================================
    // edge modes
    typedef enum logic [1:0] {
        SMI_EDGE_OFF     = 2'h0,
        SMI_EDGE_RISING  = 2'h1,
        SMI_EDGE_FALLING = 2'h2,
        SMI_EDGE_BOTH    = 2'h3
    } smi_edge_mode_type;

    // thresholds in millivolts for codes 0 to 7
    localparam logic [15:0] THRESHOLD_MV [8] = '{
        16'h07d0, 16'h0898, 16'h0960, 16'h0a8c,
        16'h0bb8, 16'h0ce4, 16'h0e10, 16'h0fa0
    };

    // ======================================================================
    // timing
    localparam int CLK_PERIOD_NS        = 8;
    localparam int MONITOR_IRQ_DELAY_NS = 1000;
    localparam int MONITOR_IRQ_DELAY_CYC =
        (MONITOR_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_W = 8;

    // ======================================================================
    // whole module state
    typedef struct packed {
        logic [7:0]         monitor_ctrl;
        logic [7:0]         edge_select;
        logic [7:0]         primary_a;
        logic [7:0]         primary_b;
        logic [7:0]         primary_c;
        logic [7:0]         multi_a;
        logic [7:0]         multi_b;
        logic [7:0]         multi_c;
        logic [1:0]         cmp_sync;
        logic [2:0]         pin_a_sync;
        logic [2:0]         pin_b_sync;
        logic [DELAY_W-1:0] delay_count;
        logic               wake;
        logic [31:0]        prdata;
        logic               pslverr;
    } smi_state_type;

endpackage
